// ===== design/mcdma_ctrl.sv
// Eight-channel DMA controller with an Avalon-MM register slave.
// Assumes a one-cycle RAM port; the peripheral port may stall with periph_busy; request lines are asynchronous.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mcdma_regs.svh"
module mcdma_ctrl
    import mcdma_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [8:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [127:0] peripheral_request_lines,
    input  wire logic [7:0]  periph_index_addr,
    output logic             periph_req,
    output logic             periph_we,
    output logic             periph_byte,
    output logic [15:0]      periph_addr,
    output logic [15:0]      periph_wdata,
    input  wire logic [15:0] periph_rdata,
    input  wire logic        periph_busy,
    output logic             ram_req,
    output logic             ram_we,
    output logic             ram_byte,
    output logic [15:0]      ram_addr,
    output logic [15:0]      ram_wdata,
    input  wire logic [15:0] ram_rdata,
    output logic [7:0]       channel_irq
);

    localparam int NCH = `MCDMA_NCH;

    logic [15:0] ctrl_reg  [NCH];
    logic [15:0] req_reg   [NCH];
    logic [15:0] sta_reg   [NCH];
    logic [15:0] stb_reg   [NCH];
    logic [15:0] pad_reg   [NCH];
    logic [9:0]  cnt_reg   [NCH];
    logic [9:0]  done_reg  [NCH];
    logic [15:0] addr_reg  [NCH];
    logic [NCH-1:0] pend_reg;
    logic [NCH-1:0] pong_reg;
    logic [NCH-1:0] second_reg;
    logic [NCH-1:0] pcol_reg;
    logic [NCH-1:0] xcol_reg;

    logic [127:0] rq_s1_reg;
    logic [127:0] rq_s2_reg;
    logic [127:0] rq_s3_reg;

    logic [NCH-1:0] trig;
    logic [NCH-1:0] collide;
    logic [15:0] cnt_wr;
    logic       go;
    logic [2:0] cur_next;

    mcdma_state_e state_reg;
    logic [2:0]  cur_reg;
    logic [15:0] data_reg;
    logic        rd_pend_reg;
    logic [31:0] rdata_reg;

    function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    logic        wr_hit;
    logic        ch_space;
    logic [2:0]  a_ch;
    logic [2:0]  a_reg;

    assign ch_space = (avs_address[8:6] == 3'h0);
    assign a_ch     = avs_address[5:3];
    assign a_reg    = avs_address[2:0];
    assign wr_hit   = avs_write && !avs_waitrequest;
    assign cnt_wr   = be_merge({6'h00, cnt_reg[a_ch]}, avs_writedata, avs_byteenable);

    // One read wait state keeps read data registered
    assign avs_waitrequest = avs_read && !rd_pend_reg;

    // Two-flop sync, then edge detect
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rq_s1_reg <= '0;
            rq_s2_reg <= '0;
            rq_s3_reg <= '0;
        end else begin
            rq_s1_reg <= peripheral_request_lines;
            rq_s2_reg <= rq_s1_reg;
            rq_s3_reg <= rq_s2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_trig
            assign trig[g] = rq_s2_reg[req_reg[g][6:0]] && !rq_s3_reg[req_reg[g][6:0]];
            assign collide[g] = trig[g] && pend_reg[g];
        end
    endgenerate

    // Software-written configuration
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                sta_reg[i] <= `MCDMA_RST16;
                stb_reg[i] <= `MCDMA_RST16;
                pad_reg[i] <= `MCDMA_RST16;
                cnt_reg[i] <= '0;
            end
        end else if (wr_hit && ch_space) begin
            case (a_reg)
                `MCDMA_R_STA: sta_reg[a_ch] <= be_merge(sta_reg[a_ch], avs_writedata, avs_byteenable);
                `MCDMA_R_STB: stb_reg[a_ch] <= be_merge(stb_reg[a_ch], avs_writedata, avs_byteenable);
                `MCDMA_R_PAD: pad_reg[a_ch] <= be_merge(pad_reg[a_ch], avs_writedata, avs_byteenable);
                `MCDMA_R_CNT: cnt_reg[a_ch] <= cnt_wr[9:0];
                default: ;
            endcase
        end
    end

    logic done_now;
    logic half_now;
    logic blk_end;
    logic stop_now;
    logic [9:0] half_pt;

    assign half_pt  = cnt_reg[cur_reg] >> 1;
    assign done_now = (state_reg == MCDMA_DONE);
    // count plus one transfers per block
    assign blk_end  = done_now && (done_reg[cur_reg] == cnt_reg[cur_reg]);
    assign half_now = done_now && (done_reg[cur_reg] == half_pt);

    // one-shot ends after one block, ping-pong after two
    assign stop_now = blk_end && ctrl_reg[cur_reg][0] && (!ctrl_reg[cur_reg][1] || second_reg[cur_reg]);

    // Control and request select
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl_reg[i] <= `MCDMA_RST16;
                req_reg[i]  <= `MCDMA_RST16;
            end
        end else begin
            if (wr_hit && ch_space && a_reg == `MCDMA_R_CTRL)
                ctrl_reg[a_ch] <= be_merge(ctrl_reg[a_ch], avs_writedata, avs_byteenable)
                                  & `MCDMA_CTRL_MASK;
            if (wr_hit && ch_space && a_reg == `MCDMA_R_REQ) begin
                req_reg[a_ch][6:0] <= avs_byteenable[0] ? avs_writedata[6:0] : req_reg[a_ch][6:0];
                if (avs_byteenable[1] && avs_writedata[`MCDMA_B_FORCE])
                    req_reg[a_ch][`MCDMA_B_FORCE] <= 1'b1;
            end
            if (stop_now)
                ctrl_reg[cur_reg][`MCDMA_B_EN] <= 1'b0;
            if (done_now)
                req_reg[cur_reg][`MCDMA_B_FORCE] <= 1'b0;
        end
    end

    // Pending requests; a trigger while pending collides
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (state_reg == MCDMA_IDLE && cur_next == 3'(i) && go)
                    pend_reg[i] <= 1'b0;
                if (trig[i] && ctrl_reg[i][`MCDMA_B_EN])
                    pend_reg[i] <= 1'b1;
            end
        end
    end

    // Shared status: hardware set beats a same-cycle software clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pcol_reg <= '0;
            xcol_reg <= '0;
        end else begin
            if (wr_hit && avs_address[6:0] == `MCDMA_R_STAT0 && !ch_space) begin
                pcol_reg <= (pcol_reg & ~(avs_byteenable[1] ? avs_writedata[15:8] : 8'h00)) | collide;
                xcol_reg <= (xcol_reg & ~(avs_byteenable[0] ? avs_writedata[7:0] : 8'h00))
                            | (collide & ~ctrl_reg_dir());
            end else begin
                pcol_reg <= pcol_reg | collide;
                xcol_reg <= xcol_reg | (collide & ~ctrl_reg_dir());
            end
        end
    end

    function automatic logic [NCH-1:0] ctrl_reg_dir();
        for (int i = 0; i < NCH; i++)
            ctrl_reg_dir[i] = ctrl_reg[i][`MCDMA_B_DIR];
    endfunction

    // Fixed priority: lowest channel with a pending request or a force
    always_comb begin
        go = 1'b0;
        cur_next = 3'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (ctrl_reg[i][`MCDMA_B_EN] && (pend_reg[i] || req_reg[i][`MCDMA_B_FORCE])) begin
                go = 1'b1;
                cur_next = 3'(i);
            end
        end
    end

    // RAM address of the current transfer
    logic [15:0] ram_addr_now;
    always_comb begin
        case (mcdma_addressing_mode_e'(ctrl_reg[cur_reg][5:4]))
            MCDMA_AM_PERIND: ram_addr_now = addr_reg[cur_reg] | {7'h00, periph_index_addr, 1'b0};
            default:         ram_addr_now = addr_reg[cur_reg];
        endcase
    end

    // Transfer engine
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= MCDMA_IDLE;
            cur_reg   <= 3'h0;
            data_reg  <= 16'h0000;
        end else begin
            case (state_reg)
                MCDMA_IDLE: begin
                    if (go) begin
                        cur_reg   <= cur_next;
                        state_reg <= MCDMA_READ;
                    end
                end
                MCDMA_READ: begin
                    if (!periph_busy) begin
                        data_reg  <= ctrl_reg[cur_reg][`MCDMA_B_DIR] ? ram_rdata : periph_rdata;
                        state_reg <= MCDMA_WRITE;
                    end
                end
                MCDMA_WRITE: begin
                    if (!periph_busy)
                        state_reg <= (ctrl_reg[cur_reg][`MCDMA_B_NULL_PERIPHERAL_WRITE] && !ctrl_reg[cur_reg][`MCDMA_B_DIR])
                                     ? MCDMA_NULL_PERIPHERAL_WRITE : MCDMA_DONE;
                end
                MCDMA_NULL_PERIPHERAL_WRITE: begin
                    if (!periph_busy)
                        state_reg <= MCDMA_DONE;
                end
                MCDMA_DONE: state_reg <= MCDMA_IDLE;
                default:    state_reg <= MCDMA_IDLE;
            endcase
        end
    end

    // Block progress, buffer choice and address stepping
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                done_reg[i] <= '0;
                addr_reg[i] <= 16'h0000;
            end
            pong_reg   <= '0;
            second_reg <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!ctrl_reg[i][`MCDMA_B_EN]) begin
                    done_reg[i]   <= '0;
                    addr_reg[i]   <= sta_reg[i];
                    pong_reg[i]   <= 1'b0;
                    second_reg[i] <= 1'b0;
                end
            end
            if (done_now) begin
                if (blk_end) begin
                    done_reg[cur_reg] <= '0;
                    // reload from the other buffer in ping-pong
                    if (ctrl_reg[cur_reg][1]) begin
                        pong_reg[cur_reg]   <= !pong_reg[cur_reg];
                        second_reg[cur_reg] <= 1'b1;
                        addr_reg[cur_reg]   <= pong_reg[cur_reg] ? sta_reg[cur_reg] : stb_reg[cur_reg];
                    end else begin
                        addr_reg[cur_reg] <= sta_reg[cur_reg];
                    end
                end else begin
                    done_reg[cur_reg] <= done_reg[cur_reg] + 10'h001;
                    if (ctrl_reg[cur_reg][5:4] == 2'b00)
                        addr_reg[cur_reg] <= addr_reg[cur_reg]
                                             + (ctrl_reg[cur_reg][`MCDMA_B_SIZE] ? 16'h0001 : 16'h0002);
                end
            end
        end
    end

    // Interrupt pulse per channel
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            channel_irq <= '0;
        end else begin
            channel_irq <= '0;
            if (ctrl_reg[cur_reg][`MCDMA_B_HALF] ? half_now : blk_end)
                channel_irq[cur_reg] <= 1'b1;
        end
    end

    // Bus drive toward peripheral and RAM
    always_comb begin
        periph_req   = 1'b0;
        periph_we    = 1'b0;
        ram_req      = 1'b0;
        ram_we       = 1'b0;
        periph_wdata = data_reg;
        ram_wdata    = data_reg;
        case (state_reg)
            MCDMA_READ: begin
                periph_req = !ctrl_reg[cur_reg][`MCDMA_B_DIR];
                ram_req    = ctrl_reg[cur_reg][`MCDMA_B_DIR];
            end
            MCDMA_WRITE: begin
                periph_req = ctrl_reg[cur_reg][`MCDMA_B_DIR];
                periph_we  = ctrl_reg[cur_reg][`MCDMA_B_DIR];
                ram_req    = !ctrl_reg[cur_reg][`MCDMA_B_DIR];
                ram_we     = !ctrl_reg[cur_reg][`MCDMA_B_DIR];
            end
            MCDMA_NULL_PERIPHERAL_WRITE: begin
                periph_req   = 1'b1;
                periph_we    = 1'b1;
                periph_wdata = `MCDMA_NULL_DATA;
            end
            default: ;
        endcase
    end
    assign periph_addr = pad_reg[cur_reg];
    assign periph_byte = ctrl_reg[cur_reg][`MCDMA_B_SIZE];
    assign ram_byte    = ctrl_reg[cur_reg][`MCDMA_B_SIZE];
    assign ram_addr    = ram_addr_now;

    // Registered read path; unmapped words read zero, except aliases whose bits 6-0 match a status word
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_pend_reg <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
        end else begin
            rd_pend_reg <= avs_read && !rd_pend_reg;
            rdata_reg   <= 32'h0000_0000;
            if (ch_space) begin
                case (a_reg)
                    `MCDMA_R_CTRL: rdata_reg[15:0] <= ctrl_reg[a_ch];
                    `MCDMA_R_REQ:  rdata_reg[15:0] <= req_reg[a_ch] & `MCDMA_REQ_MASK;
                    `MCDMA_R_STA:  rdata_reg[15:0] <= sta_reg[a_ch];
                    `MCDMA_R_STB:  rdata_reg[15:0] <= stb_reg[a_ch];
                    `MCDMA_R_PAD:  rdata_reg[15:0] <= pad_reg[a_ch];
                    `MCDMA_R_CNT:  rdata_reg[15:0] <= {6'h00, cnt_reg[a_ch]};
                    default: ;
                endcase
            end else if (avs_address[6:0] == `MCDMA_R_STAT0) begin
                rdata_reg[15:0] <= {pcol_reg, xcol_reg};
            end else if (avs_address[6:0] == `MCDMA_R_STAT1) begin
                rdata_reg[15:0] <= {8'h00, pend_reg};
            end
        end
    end
    assign avs_readdata = rdata_reg;
endmodule
`default_nettype wire

// ===== design/mcdma_regs.svh
// DMA controller register map and field constants.
// Assumes a 16-bit register view carried in the low bits of 32-bit Avalon words.
// Behaviour
// - Eight identical channels, each with its own register set.
// - Per channel: control, request select, two RAM starts, peripheral address, 10-bit count.
// - Two status registers are shared by all channels.
// - Channel moves data only while control bit 15 is set.
// - Control bit 14 set selects bytes, clear selects words.
// - Control bit 13 set reads RAM and writes peripheral; clear the reverse.
// - Each channel interrupts at block end unless half-block is chosen.
// - Control bit 12 set moves the interrupt to the half-block point.
// - Bit 11 adds a null peripheral write per RAM write; needs direction 0.
// - Bits 5-4 choose post-increment, no increment, peripheral indirect, or reserved.
// - Peripheral indirect takes part of the RAM address from the peripheral.
// - Bits 1-0 choose continuous or one-shot, with or without ping-pong.
// - One-shot stops after one block.
// - Continuous reloads the RAM start after each block and goes on.
// - Ping-pong alternates primary and secondary starts on successive blocks.
// - One-shot ping-pong moves one block from each buffer, then stops.
// - Force bit 15 of request select starts one transfer by hand.
// - Only hardware clears force, when the forced transfer ends.
// - Bits 6-0 of request select pick one of 128 request lines.
// - Each channel may select among at least 20 peripherals.
// - Unused control and request-select bits read as zero.
// - A block is the count value plus one transfers.
// - Shared status holds per-channel write collision flags; software only clears them.
`ifndef MCDMA_REGS_SVH
`define MCDMA_REGS_SVH
`define MCDMA_NCH           8
// Per-channel word index: channel*8 + register
`define MCDMA_R_CTRL        3'h0
`define MCDMA_R_REQ         3'h1
`define MCDMA_R_STA         3'h2
`define MCDMA_R_STB         3'h3
`define MCDMA_R_PAD         3'h4
`define MCDMA_R_CNT         3'h5
`define MCDMA_R_STAT0       7'h40
`define MCDMA_R_STAT1       7'h41
`define MCDMA_B_EN          15
`define MCDMA_B_SIZE        14
`define MCDMA_B_DIR         13
`define MCDMA_B_HALF        12
`define MCDMA_B_NULL_PERIPHERAL_WRITE       11
`define MCDMA_B_FORCE       15
`define MCDMA_CTRL_MASK     16'hf833
`define MCDMA_REQ_MASK      16'h807f
`define MCDMA_CNT_MASK      16'h03ff
`define MCDMA_RST16         16'h0000
`define MCDMA_NULL_DATA     16'h0000
`endif

// ===== design/mcdma_pkg.sv
// Types shared by the DMA controller.
// Assumes mcdma_regs.svh for numeric constants.
package mcdma_pkg;
    typedef enum logic [2:0] {
        MCDMA_IDLE  = 3'b000,
        MCDMA_READ  = 3'b001,
        MCDMA_WRITE = 3'b010,
        MCDMA_NULL_PERIPHERAL_WRITE = 3'b011,
        MCDMA_DONE  = 3'b100
    } mcdma_state_e;
    typedef enum logic [1:0] {
        MCDMA_AM_POSTINC = 2'b00,
        MCDMA_AM_NOINC   = 2'b01,
        MCDMA_AM_PERIND  = 2'b10,
        MCDMA_AM_RSVD    = 2'b11
    } mcdma_addressing_mode_e;
endpackage

// ===== sim/mcdma_ctrl_properties.sv
// Concurrent checks on the ports of the DMA controller.
// Assumes one sys_clk domain; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module mcdma_ctrl_properties (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic        periph_req,
    input wire logic        periph_busy,
    input wire logic [15:0] periph_addr,
    input wire logic        ram_req,
    input wire logic [7:0]  channel_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_rd_wait;
        avs_read && avs_waitrequest;
    endsequence
    sequence s_rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    a_read_one_wait: assert property (s_rd_wait |=> s_rd_done)
        else $error("read wait longer than one cycle");
    a_read_first_wait: assert property ($rose(avs_read) |-> s_rd_wait)
        else $error("read answered without wait");
    a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    a_upper_half_zero: assert property (s_rd_done |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_irq_one_cycle: assert property (channel_irq != 8'h00 |=> (channel_irq & $past(channel_irq)) == 8'h00)
        else $error("interrupt longer than one cycle");
    a_one_bus_side: assert property (!(ram_req && periph_req))
        else $error("both buses driven at once");
    a_busy_holds_access: assert property (periph_req && periph_busy |=> periph_req && $stable(periph_addr))
        else $error("access dropped under stall");
    a_reset_quiet: assert property ($rose(arst_n) |-> !ram_req && !periph_req && channel_irq == 8'h00)
        else $error("activity right after reset");
endmodule
bind mcdma_ctrl mcdma_ctrl_properties u_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .periph_req(periph_req),
    .periph_busy(periph_busy), .periph_addr(periph_addr), .ram_req(ram_req), .channel_irq(channel_irq)
);
`default_nettype wire

// ===== sim/mcdma_periph_model.sv
// Peripheral side model: one data register, request lines and optional stall.
// Assumes single-cycle accesses unless slow is set by the bench.
`timescale 1ns/1ps
`default_nettype none
module mcdma_periph_model (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic         periph_req,
    input  wire logic         periph_we,
    input  wire logic [15:0]  periph_addr,
    input  wire logic [15:0]  periph_wdata,
    input  wire logic         slow,
    input  wire logic [127:0] raise,
    output logic [15:0]       periph_rdata,
    output logic              periph_busy,
    output logic [127:0]      peripheral_request_lines,
    output logic [15:0]       last_addr,
    output logic [15:0]       last_wdata,
    output logic [7:0]        n_rd,
    output logic [7:0]        n_wr
);
    logic        held_reg;
    logic [15:0] shown_reg;
    // Slow mode stalls the first cycle of every access
    assign periph_busy = slow && periph_req && !held_reg;
    // Idle bus shows the inverse of the last value so stale data never matches
    assign periph_rdata = periph_req ? 16'ha500 + {8'h00, n_rd} : ~shown_reg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            held_reg <= 1'b0;
            shown_reg <= 16'h0000;
            peripheral_request_lines <= '0;
            last_addr <= 16'h0000;
            last_wdata <= 16'hffff;
            n_rd <= 8'h00;
            n_wr <= 8'h00;
        end else begin
            held_reg <= periph_req && periph_busy;
            peripheral_request_lines <= raise;
            if (periph_req && !periph_busy) begin
                last_addr <= periph_addr;
                if (periph_we) begin
                    n_wr <= n_wr + 8'h01;
                    last_wdata <= periph_wdata;
                end else begin
                    n_rd <= n_rd + 8'h01;
                    shown_reg <= periph_rdata;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Bench: register map, then transfers in each block mode.
// Assumes the peripheral model; a word RAM model lives here.
`timescale 1ns/1ps
`default_nettype none
`include "mcdma_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("BAD %0t %h %h", $time, g, e); end end
module tb_top;
    typedef struct packed { logic [8:0] a; logic [15:0] d; logic [15:0] e; } mcdma_row_s;
    logic         sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, slow, rb, pb;
    logic         periph_req, periph_we, periph_byte, periph_busy, ram_req, ram_we, ram_byte;
    logic [8:0]   avs_address;
    logic [31:0]  avs_writedata, avs_readdata;
    logic [127:0] raise, req_lines;
    logic [7:0]   idx, channel_irq, n_rd, n_wr;
    logic [15:0]  periph_addr, periph_wdata, periph_rdata, ram_addr, ram_wdata, ram_rdata;
    logic [15:0]  last_addr, last_wdata, q, ra;
    logic [15:0]  ram [0:255];
    logic [15:0]  wq [$];
    int           failures = 0, n_tests = 0, nirq = 0, act = 0, b, i0, w0;
    mcdma_row_s   rows [0:7] = '{'{9'h000, 16'h7fff, 16'h7833}, '{9'h039, 16'h7fff, 16'h007f},
        '{9'h03a, 16'h1234, 16'h1234}, '{9'h03d, 16'hffff, 16'h03ff}, '{9'h006, 16'hffff, 16'h0000},
        '{9'h1c0, 16'hffff, 16'h0000}, '{9'h040, 16'hffff, 16'h0000}, '{9'h038, 16'h7833, 16'h7833}};
    mcdma_ctrl dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .peripheral_request_lines(req_lines),
        .periph_index_addr(idx), .periph_req(periph_req), .periph_we(periph_we), .periph_byte(periph_byte),
        .periph_addr(periph_addr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
        .periph_busy(periph_busy), .ram_req(ram_req), .ram_we(ram_we), .ram_byte(ram_byte),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .channel_irq(channel_irq));
    mcdma_periph_model per_u (.sys_clk(sys_clk), .arst_n(arst_n), .periph_req(periph_req),
        .periph_we(periph_we), .periph_addr(periph_addr), .periph_wdata(periph_wdata), .slow(slow),
        .raise(raise), .periph_rdata(periph_rdata), .periph_busy(periph_busy),
        .peripheral_request_lines(req_lines), .last_addr(last_addr), .last_wdata(last_wdata),
        .n_rd(n_rd), .n_wr(n_wr));
    always #50 sys_clk = ~sys_clk;
    assign ram_rdata = ram[ram_addr[8:1]];
    always @(posedge sys_clk) begin
        if (ram_req && ram_we) begin
            ram[ram_addr[8:1]] <= ram_wdata;
            wq.push_back(ram_addr);
            rb <= ram_byte;
        end
        if (ram_req && !ram_we) ra <= ram_addr;
        if (periph_req && periph_we) pb <= periph_byte;
        if (ram_req || periph_req) act <= act + 1;
        nirq <= nirq + $countones(channel_irq);
    end
    task automatic bus(input logic [8:0] a, input logic w = 1'b0, input logic [15:0] d = 16'h0000);
        int k;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0000, d};
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) failures++;
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Returns after eight quiet cycles
    task automatic settle;
        int s, l, k;
        s = 0;
        k = 0;
        l = act;
        while (s < 8 && k < 300) begin
            @(posedge sys_clk);
            k++;
            s = (act == l) ? s + 1 : 0;
            l = act;
        end
        if (k >= 300) failures++;
    endtask
    task automatic trig(input int n);
        raise[n] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        raise[n] <= 1'b0;
        settle;
    endtask
    // Control last, so the channel is off while the others change
    task automatic cfg(input logic [2:0] c, input logic [15:0] ct, rq, sa, sb, pd, cn);
        logic [15:0] v [6];
        v = '{sa, sb, pd, cn, rq, ct};
        for (int r = 0; r < 6; r++)
            bus({3'h0, c, 3'(r < 4 ? r + 2 : 5 - r)}, 1'b1, v[r]);
    endtask
    task automatic print_verdict;
        $display("counts: %0d compares, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        print_verdict;
    end
    initial begin
        {sys_clk, arst_n, avs_read, avs_write, slow, avs_address, avs_writedata, raise} = '0;
        idx = 8'h01;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        for (int c = 0; c < 48; c++) begin
            bus({3'h0, c[5:3], c[2:0] % 3'h6});
            `CHK(q, `MCDMA_RST16)
        end
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            bus(rows[i].a, 1'b1, rows[i].d);
            bus(rows[i].a);
            `CHK(q, rows[i].e)
        end
        bus(9'h000, 1'b1, 16'h0000);
        bus(9'h038, 1'b1, 16'h0000);
        $display("register table done");
        b = n_rd;
        i0 = nirq;
        wq.delete();
        cfg(3'h0, 16'h8001, 16'h0005, 16'h0040, 16'h0080, 16'h0100, 16'h0003);
        repeat (4) trig(5);
        for (int k = 0; k < 4; k++) begin
            `CHK(wq[k], 16'(16'h0040 + 2 * k))
            `CHK(ram[8'h20 + k], 16'(16'ha500 + b + k))
        end
        `CHK(rb, 1'b0)
        `CHK(nirq - i0, 1)
        trig(5);
        `CHK(wq.size(), 4)
        bus(9'h000);
        `CHK(q[15], 1'b0)
        $display("one-shot word in done");
        slow <= 1'b1;
        i0 = nirq;
        w0 = n_wr;
        cfg(3'h1, 16'h7011, 16'h8000, 16'h0060, 16'h0000, 16'h0010, 16'h0003);
        bus(9'h009, 1'b1, 16'h0000);
        bus(9'h009);
        `CHK(q[15], 1'b1)
        `CHK(n_wr - w0, 0)
        bus(9'h008, 1'b1, 16'hf011);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) bus(9'h009, 1'b1, 16'h8000);
            settle;
            bus(9'h009);
            `CHK(q[15], 1'b0)
            if (k == 1) `CHK(nirq - i0, 1)
        end
        `CHK(nirq - i0, 1)
        `CHK(n_wr - w0, 4)
        `CHK(last_addr, 16'h0010)
        `CHK(ra, 16'h0060)
        `CHK(pb, 1'b1)
        slow <= 1'b0;
        $display("forced byte out done");
        wq.delete();
        cfg(3'h2, 16'h8002, 16'h0009, 16'h00a0, 16'h00c0, 16'h0020, 16'h0000);
        repeat (3) trig(9);
        `CHK(wq[0], 16'h00a0)
        `CHK(wq[1], 16'h00c0)
        `CHK(wq[2], 16'h00a0)
        bus(9'h010, 1'b1, 16'h0000);
        trig(9);
        `CHK(wq.size(), 3)
        cfg(3'h4, 16'h8000, 16'h000b, 16'h00e0, 16'h0000, 16'h0020, 16'h0000);
        repeat (2) trig(11);
        `CHK(wq[4], 16'h00e0)
        bus(9'h020, 1'b1, 16'h0000);
        $display("continuous modes done");
        wq.delete();
        w0 = n_wr;
        cfg(3'h3, 16'h8823, 16'h000c, 16'h0100, 16'h0200, 16'h0030, 16'h0000);
        repeat (3) trig(12);
        `CHK(wq.size(), 2)
        `CHK(wq[0], 16'h0102)
        `CHK(wq[1], 16'h0202)
        `CHK(n_wr - w0, 2)
        `CHK(last_wdata, `MCDMA_NULL_DATA)
        $display("ping-pong indirect done");
        print_verdict;
    end
endmodule
`default_nettype wire
